// [design/idle_ctrl_pkg.sv]
// Package of offsets, field positions, reset values and states for idle control
package idle_ctrl_pkg;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // Control register field positions
    localparam int IDLE_SELECT_BIT = 0;
    localparam int DOZE_ENABLE_BIT = 1;
    localparam int RECOVER_ON_IRQ_BIT = 2;
    localparam int GLOBAL_IRQ_ENABLE_BIT = 3;
    localparam int CLOCK_PIN_OUTPUT_N_BIT = 4;
    localparam int CTRL_WIDTH = 5;

    // Status register field positions
    localparam int MODE_LSB = 0;
    localparam int WAKE_IRQ_BIT = 2;
    localparam int WAKE_WDT_BIT = 3;
    localparam int FULL_SPEED_BIT = 4;

    // Reset values: clock output disabled (active low bit set)
    localparam logic [4:0] CTRL_RESET = 5'h10;
    localparam logic [1:0] WAKE_RESET = 2'h0;

    // Power modes as seen in the status register
    localparam logic [1:0] MODE_CODE_RUN = 2'h0;
    localparam logic [1:0] MODE_CODE_IDLE = 2'h1;
    localparam logic [1:0] MODE_CODE_SLEEP = 2'h2;

    typedef enum {
        PM_RUN,
        PM_IDLE,
        PM_SLEEP
    } power_mode_t;

endpackage : idle_ctrl_pkg

// [design/idle_power_mode_control.sv]
// Idle and Sleep power mode controller with APB register access
`timescale 1ns/10ps
module idle_power_mode_control
    import idle_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleepExec,
    input wire logic irqEvent,
    input wire logic wdtTimeout,
    output logic cpuHalt,
    output logic flashOff,
    output logic sysPeriphClkEn,
    output logic oscPeriphClkEn,
    output logic clkPinOut,
    output logic resumeNext,
    output logic irqToCpu,
    output logic wdtResetReq,
    output logic fullSpeedRestore
);

    power_mode_t mode_r;
    power_mode_t mode_nxt;
    logic [CTRL_WIDTH-1:0] ctrl_r;
    logic [1:0] wake_r;
    logic clkToggle_r;
    logic apbSetup;
    logic apbAccess;
    logic apbWrite;
    logic hitCtrl;
    logic hitStatus;
    logic idleSelect;
    logic dozeEnable;
    logic recoverOnIrq;
    logic globalIrqEnable;
    logic clockPinOutput_n;
    logic wakeIrq;
    logic wakeWdt;
    logic irqRecover;
    logic [1:0] modeCode;

    assign idleSelect = ctrl_r[IDLE_SELECT_BIT];
    assign dozeEnable = ctrl_r[DOZE_ENABLE_BIT];
    assign recoverOnIrq = ctrl_r[RECOVER_ON_IRQ_BIT];
    assign globalIrqEnable = ctrl_r[GLOBAL_IRQ_ENABLE_BIT];
    assign clockPinOutput_n = ctrl_r[CLOCK_PIN_OUTPUT_N_BIT];

    // APB decode: zero wait states, unmapped addresses answer with an error
    assign apbSetup = psel & ~penable;
    assign apbAccess = psel & penable;
    assign hitCtrl = (paddr == CTRL_OFFSET);
    assign hitStatus = (paddr == STATUS_OFFSET);
    assign apbWrite = apbAccess & pwrite;
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~hitCtrl & ~hitStatus;

    // Wake causes; an interrupt wins when both arrive together
    assign wakeIrq = (mode_r != PM_RUN) & irqEvent;
    assign wakeWdt = (mode_r != PM_RUN) & wdtTimeout & ~irqEvent;
    // Speed recovery only for an interrupt leaving Idle; a watchdog wake or
    // a wake from Sleep leaves doze_enable as software set it
    assign irqRecover = (mode_r == PM_IDLE) & wakeIrq & recoverOnIrq
        & dozeEnable;

    // Mode encoding for status readback
    always_comb begin
        case (mode_r)
            PM_IDLE: begin
                modeCode = MODE_CODE_IDLE;
            end
            PM_SLEEP: begin
                modeCode = MODE_CODE_SLEEP;
            end
            default: begin
                modeCode = MODE_CODE_RUN;
            end
        endcase
    end

    // Power mode next state
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            PM_RUN: begin
                if (sleepExec) begin
                    if (idleSelect) begin
                        mode_nxt = PM_IDLE;
                    end else begin
                        mode_nxt = PM_SLEEP;
                    end
                end
            end
            PM_IDLE: begin
                if (irqEvent || wdtTimeout) begin
                    mode_nxt = PM_RUN;
                end
            end
            PM_SLEEP: begin
                if (irqEvent || wdtTimeout) begin
                    mode_nxt = PM_RUN;
                end
            end
            default: begin
                mode_nxt = PM_RUN;
            end
        endcase
    end

    // Power mode register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_r <= PM_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Control register; hardware recovery clears doze over a same-cycle write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (apbWrite && hitCtrl) begin
                ctrl_r <= pwdata[CTRL_WIDTH-1:0];
            end
            if (irqRecover) begin
                ctrl_r[DOZE_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // Sticky wake cause flags, write one to clear, a new set wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wake_r <= WAKE_RESET;
        end else begin
            if (wakeIrq) begin
                wake_r[0] <= 1'b1;
            end else if (apbWrite && hitStatus && pwdata[WAKE_IRQ_BIT]) begin
                wake_r[0] <= 1'b0;
            end
            if (wakeWdt) begin
                wake_r[1] <= 1'b1;
            end else if (apbWrite && hitStatus && pwdata[WAKE_WDT_BIT]) begin
                wake_r[1] <= 1'b0;
            end
        end
    end

    // Read data captured in the setup cycle, valid during the access phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (apbSetup && !pwrite) begin
            prdata <= 32'h00000000;
            if (hitCtrl) begin
                prdata[CTRL_WIDTH-1:0] <= ctrl_r;
            end else if (hitStatus) begin
                prdata[MODE_LSB+1:MODE_LSB] <= modeCode;
                prdata[WAKE_IRQ_BIT] <= wake_r[0];
                prdata[WAKE_WDT_BIT] <= wake_r[1];
                prdata[FULL_SPEED_BIT] <= ~dozeEnable;
            end
        end
    end

    // Core and flash gating from the next mode so they track the mode register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cpuHalt <= 1'b0;
            flashOff <= 1'b0;
            sysPeriphClkEn <= 1'b1;
            oscPeriphClkEn <= 1'b1;
        end else begin
            cpuHalt <= (mode_nxt != PM_RUN);
            flashOff <= (mode_nxt != PM_RUN);
            sysPeriphClkEn <= (mode_nxt != PM_SLEEP);
            oscPeriphClkEn <= 1'b1;
        end
    end

    // Clock output toggles whenever the system clock runs and it is enabled
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clkToggle_r <= 1'b0;
        end else if (!clockPinOutput_n && mode_r != PM_SLEEP) begin
            clkToggle_r <= ~clkToggle_r;
        end else begin
            clkToggle_r <= 1'b0;
        end
    end
    assign clkPinOut = clkToggle_r;

    // Wake, interrupt, watchdog and recovery pulses toward the core
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resumeNext <= 1'b0;
            irqToCpu <= 1'b0;
            wdtResetReq <= 1'b0;
            fullSpeedRestore <= 1'b0;
        end else begin
            resumeNext <= wakeIrq | wakeWdt;
            irqToCpu <= irqEvent & globalIrqEnable;
            wdtResetReq <= wdtTimeout & (mode_r == PM_RUN);
            fullSpeedRestore <= irqRecover;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    AST_SLEEP_ENTRY: assert property (
        (mode_r == PM_RUN) && sleepExec && !idleSelect
        |=> (mode_r == PM_SLEEP) && cpuHalt && !sysPeriphClkEn)
        else $error("Sleep not entered with idle_select clear");

    AST_IDLE_ENTRY: assert property (
        (mode_r == PM_RUN) && sleepExec && idleSelect
        |=> (mode_r == PM_IDLE))
        else $error("Idle not entered with idle_select set");

    AST_IDLE_GATING: assert property (
        (mode_r == PM_IDLE) |-> cpuHalt && flashOff && sysPeriphClkEn)
        else $error("Idle gating wrong");

    AST_SYSCLK_SLEEP: assert property (
        (mode_r == PM_SLEEP) |-> !sysPeriphClkEn)
        else $error("System peripherals clocked in Sleep");

    AST_OSC_RUNS: assert property (
        $past(!sys_rst) |-> oscPeriphClkEn)
        else $error("Oscillator peripherals stopped");

    AST_CLOCK_PIN_IDLE: assert property (
        (mode_r == PM_IDLE) && !clockPinOutput_n
        && $past(mode_r == PM_IDLE) && $past(!clockPinOutput_n)
        |-> clkPinOut != $past(clkPinOut))
        else $error("Clock output stalled in Idle");

    AST_IRQ_WAKE: assert property (
        (mode_r == PM_IDLE) && irqEvent
        |=> (mode_r == PM_RUN) && !cpuHalt && !flashOff && resumeNext)
        else $error("Interrupt did not end Idle");

    AST_IDLESEL_KEPT: assert property (
        (mode_r == PM_IDLE) && (mode_nxt == PM_RUN)
        && !(apbWrite && hitCtrl) |=> $stable(idleSelect))
        else $error("idle_select changed on wake");

    AST_IRQ_RECOVER: assert property (
        (mode_r == PM_IDLE) && irqEvent && recoverOnIrq && dozeEnable
        |=> !dozeEnable && fullSpeedRestore)
        else $error("Recovery on interrupt missing");

    AST_WDT_NO_RESET: assert property (
        (mode_r == PM_IDLE) && wdtTimeout
        |=> !wdtResetReq && resumeNext && (mode_r == PM_RUN))
        else $error("Watchdog reset in Idle");

    AST_WDT_NO_RECOVER: assert property (
        (mode_r == PM_IDLE) && wdtTimeout && !irqEvent
        && !(apbWrite && hitCtrl) |=> $stable(dozeEnable) && !fullSpeedRestore)
        else $error("Watchdog wake touched doze");

    AST_RESUME_ONCE: assert property (
        resumeNext |-> $past(mode_r != PM_RUN) && (mode_r == PM_RUN)
        ##1 !resumeNext)
        else $error("Resume pulse wrong");

    // Wake paths, gating levels, pulses and register side effects
    AST_SLEEP_WAKE: assert property (
        (mode_r == PM_SLEEP) && (irqEvent || wdtTimeout)
        |=> (mode_r == PM_RUN) && !cpuHalt && sysPeriphClkEn)
        else $error("Sleep wake did not restart the core");

    AST_RUN_UNGATED: assert property (
        (mode_r == PM_RUN) |-> !cpuHalt && !flashOff)
        else $error("Core or flash gated while running");

    AST_SYSCLK_LEVEL: assert property (
        sysPeriphClkEn == (mode_r != PM_SLEEP))
        else $error("System peripheral clock enable out of step");

    AST_WDT_RESET_RUN: assert property (
        (mode_r == PM_RUN) && wdtTimeout |=> wdtResetReq && !resumeNext)
        else $error("Watchdog timeout while running gave no reset");

    AST_WDT_PULSE: assert property (
        wdtResetReq |-> $past(wdtTimeout) && $past(mode_r == PM_RUN))
        else $error("Watchdog reset request without cause");

    AST_IRQ_GATED: assert property (
        irqToCpu |-> $past(irqEvent) && $past(globalIrqEnable))
        else $error("Interrupt passed to core while masked");

    AST_CLOCK_PIN_SLEEP: assert property (
        $past(mode_r == PM_SLEEP) |-> !clkPinOut)
        else $error("Clock pin toggled in Sleep");

    AST_IRQ_FLAG: assert property (
        (mode_r != PM_RUN) && irqEvent |=> wake_r[0] && resumeNext)
        else $error("Interrupt wake not recorded");

    AST_WDT_FLAG: assert property (
        (mode_r != PM_RUN) && wdtTimeout && !irqEvent
        |=> wake_r[1] && resumeNext)
        else $error("Watchdog wake not recorded");

    AST_SLEEP_NO_RECOVER: assert property (
        (mode_r == PM_SLEEP) |=> !fullSpeedRestore)
        else $error("Speed restored on a wake from Sleep");

    AST_RESTORE_PULSE: assert property (
        fullSpeedRestore |=> !fullSpeedRestore)
        else $error("Speed restore pulse too long");

    AST_DOZE_FALL: assert property (
        $fell(dozeEnable) |-> $past(irqRecover)
        || $past(apbWrite && hitCtrl) || $past(sys_rst))
        else $error("doze_enable cleared without cause");

    AST_CTRL_WRITE: assert property (
        apbWrite && hitCtrl && !irqRecover
        |=> ctrl_r == $past(pwdata[CTRL_WIDTH-1:0]))
        else $error("Control write did not land");

endmodule : idle_power_mode_control

// [verification/cpu_side_model.sv]
// Behavioural CPU core, interrupt source and watchdog facing the block
`timescale 1ns/10ps
module cpu_side_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [2:0] goReq,
    input wire logic cpuHalt,
    input wire logic resumeNext,
    input wire logic fullSpeedRestore,
    output logic sleepExec,
    output logic irqEvent,
    output logic wdtTimeout,
    output int pcCount,
    output int restoreCount
);
    // Bench requests become one-cycle pulses; a halted core executes nothing
    always_ff @(posedge core_clk) begin
        sleepExec <= goReq[0] && !cpuHalt && !sys_rst;
        irqEvent <= goReq[1] && !sys_rst;
        wdtTimeout <= goReq[2] && !sys_rst;
    end
    // Counts resumed instructions and speed restores
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pcCount <= 0;
            restoreCount <= 0;
        end else begin
            pcCount <= pcCount + (resumeNext ? 1 : 0);
            restoreCount <= restoreCount + (fullSpeedRestore ? 1 : 0);
        end
    end
endmodule : cpu_side_model

// [verification/idle_power_mode_control_tb.sv]
// Self-checking bench for the idle power mode controller
`timescale 1ns/10ps
module idle_power_mode_control_tb;
    import idle_ctrl_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, sleepExec, irqEvent, wdtTimeout, err;
    logic cpuHalt, flashOff, sysPeriphClkEn, oscPeriphClkEn, clkPinOut;
    logic resumeNext, irqToCpu, wdtResetReq, fullSpeedRestore, a;
    logic [2:0] goReq = 3'h0;
    int pcCount, restoreCount, badCount = 0, cmpCount = 0, rstReqs = 0, r;
    int irqReqs = 0, q;
    idle_power_mode_control u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleepExec(sleepExec), .irqEvent(irqEvent),
        .wdtTimeout(wdtTimeout), .cpuHalt(cpuHalt), .flashOff(flashOff),
        .sysPeriphClkEn(sysPeriphClkEn), .oscPeriphClkEn(oscPeriphClkEn),
        .clkPinOut(clkPinOut), .resumeNext(resumeNext),
        .irqToCpu(irqToCpu), .wdtResetReq(wdtResetReq),
        .fullSpeedRestore(fullSpeedRestore));
    cpu_side_model u_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .goReq(goReq), .cpuHalt(cpuHalt), .resumeNext(resumeNext),
        .fullSpeedRestore(fullSpeedRestore), .sleepExec(sleepExec),
        .irqEvent(irqEvent), .wdtTimeout(wdtTimeout), .pcCount(pcCount),
        .restoreCount(restoreCount));
    // Clock of 50 ns period
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Counts watchdog reset requests and interrupts passed to the core
    always @(posedge core_clk) begin
        if (wdtResetReq === 1'b1) rstReqs++;
        if (irqToCpu === 1'b1) irqReqs++;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready however long the slave takes
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Bit 0 sleep, bit 1 interrupt, bit 2 watchdog; fixed model+block latency
    task kick(input logic [2:0] m);
        @(posedge core_clk);
        goReq <= m;
        @(posedge core_clk);
        goReq <= 3'h0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask : kick
    task testReset;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h00000010);
        apb(1'b0, 12'h008, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        chk({cpuHalt, sysPeriphClkEn, oscPeriphClkEn}, 32'h3);
    endtask : testReset
    task testIdle;
        apb(1'b1, CTRL_OFFSET, 32'h00000001);
        kick(3'h1);
        chk({cpuHalt, flashOff, sysPeriphClkEn, oscPeriphClkEn}, 32'hF);
        a = clkPinOut;
        @(negedge core_clk);
        chk(a ^ clkPinOut, 32'h1);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd[1:0], MODE_CODE_IDLE);
        r = pcCount;
        q = irqReqs;
        kick(3'h2);
        chk(cpuHalt, 1'b0);
        chk(pcCount, r + 1);
        chk(irqReqs, q);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h00000001);
        kick(3'h1);
        chk(cpuHalt, 1'b1);
        kick(3'h2);
    endtask : testIdle
    task testRecover;
        apb(1'b1, CTRL_OFFSET, 32'h0000000F);
        kick(3'h1);
        r = restoreCount;
        q = irqReqs;
        kick(3'h2);
        chk(restoreCount, r + 1);
        chk(irqReqs, q + 1);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0000000D);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h00000014);
        apb(1'b1, STATUS_OFFSET, 32'h00000004);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h00000010);
    endtask : testRecover
    task testWdt;
        apb(1'b1, CTRL_OFFSET, 32'h00000007);
        kick(3'h1);
        r = restoreCount;
        q = rstReqs;
        kick(3'h4);
        chk(cpuHalt, 1'b0);
        chk(rstReqs, q);
        chk(restoreCount, r);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h00000007);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h00000008);
        r = rstReqs;
        kick(3'h4);
        chk(rstReqs, r + 1);
    endtask : testWdt
    task testSleep;
        apb(1'b1, CTRL_OFFSET, 32'h00000000);
        kick(3'h1);
        chk({cpuHalt, flashOff, sysPeriphClkEn, oscPeriphClkEn}, 32'hD);
        @(negedge core_clk);
        chk(clkPinOut, 1'b0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd[1:0], MODE_CODE_SLEEP);
        kick(3'h2);
        chk({cpuHalt, oscPeriphClkEn}, 32'h1);
    endtask : testSleep
    task finishTest;
        $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finishTest
    // Watchdog for a hung run
    initial begin
        #100000;
        badCount++;
        $display("[FAIL] %0t run timed out", $time);
        finishTest();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        testReset();
        testIdle();
        testRecover();
        testWdt();
        testSleep();
        finishTest();
    end
endmodule : idle_power_mode_control_tb
